/* resr_regs.v */
// Purpose: rail enable, discharge, sense and event registers of the regulator block
// Assumes: register port and sense inputs synchronous to sys_clk
// Notes: serial protocol lives outside; rd/wr are one-cycle strobes
//
// Functional notes
// R1: bit 7 picks buck level one or two
// R2: bit 5 switches the buck on
// R3: bits 4..0 switch linear regulators on
// R4: thermal policy 10 means no restart
// R5: policy 01 restarts, keeps register contents
// R6: policy 00 resets registers, then restarts
// R7: discharge bit 5 enables buck discharge
// R8: discharge bits 4..0 enable linear discharge
// R9: undervoltage sense with hysteresis release
// R10: sequence sense low only while sequencing
// R11: shutdown sense follows over-temperature comparator
// R12: warning sense follows warning comparator
// R13: undervoltage event on either edge
// R14: sequence event on rising edge only
// R15: thermal events on either edge
// R16: sequence ends sixteen 128 us slots after enable
// R17: event read returns flags, clears them
// R18: spare bits read zero, read-only writes ignored
`timescale 1ns/1ps
`default_nettype none
`include "resr_defs.vh"
module resr_regs #(
    parameter SLOT_CYC = `RESR_SEQ_SLOT_CYC
) (
    input wire sys_clk, // 200 MHz clock
    input wire rst_n, // async reset, low
    input wire [7:0] reg_addr, // register offset
    input wire [7:0] reg_wdata, // write data
    input wire reg_wr, // write strobe
    input wire reg_rd, // read strobe
    output reg [7:0] reg_rdata, // read data, valid cycle after reg_rd
    input wire hw_enable_pin, // hardware enable
    input wire uv_below, // supply below lockout threshold
    input wire uv_above_hyst, // supply above threshold plus hysteresis
    input wire temp_over_shutdown, // die over shutdown threshold
    input wire temp_over_warning, // die over warning threshold
    output reg buck_level_select, // 1 level one, 0 level two
    output reg buck_on, // buck converter enable
    output reg [4:0] linear_reg_on, // linear regulators 5..1 enable
    output reg buck_discharge_on, // buck active discharge
    output reg [4:0] linear_reg_discharge_on, // linear 5..1 discharge
    output reg sequencing // power-up sequence running
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    reg [7:0] rail_enable_ctrl;
    reg [7:0] discharge_rearm_ctrl;
    reg undervoltage_sense;
    reg overtemp_shutdown_sense;
    reg overtemp_warning_sense;
    reg seq_run;
    reg [14:0] slot_cnt;
    reg [4:0] slot_num;
    reg hw_prev;
    reg tsd_prev;
    reg no_restart;
    wire sequence_done_sense;
    wire slot_tick;
    wire tsd_end;
    wire [1:0] policy;
    wire ev_read;
    wire undervoltage_event;
    wire sequence_done_event;
    wire overtemp_shutdown_event;
    wire overtemp_warning_event;
    wire [7:0] sense_word;
    wire [7:0] event_word;

    // ----------------------------------------
    // sequence timing limits
    // ----------------------------------------
    localparam [31:0] SLOT_LAST_FULL = SLOT_CYC - 1;
    localparam [14:0] SLOT_LAST = SLOT_LAST_FULL[14:0]; // 15 bits hold the longest slot

    assign policy = discharge_rearm_ctrl[`RESR_POLICY_HI:`RESR_POLICY_LO];
    assign tsd_end = tsd_prev & ~overtemp_shutdown_sense;
    assign sequence_done_sense = ~seq_run; // R10
    assign slot_tick = seq_run && (slot_cnt == SLOT_LAST);
    assign ev_read = reg_rd && (reg_addr == `RESR_ADDR_EVENT);

    // ----------------------------------------
    // live sense flags
    // ----------------------------------------
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            undervoltage_sense <= 1'b0;
            overtemp_shutdown_sense <= 1'b0;
            overtemp_warning_sense <= 1'b0;
            tsd_prev <= 1'b0;
        end else begin
            if (uv_below) begin
                undervoltage_sense <= 1'b1; // R9
            end else if (uv_above_hyst) begin
                undervoltage_sense <= 1'b0; // R9
            end
            overtemp_shutdown_sense <= temp_over_shutdown; // R11
            overtemp_warning_sense <= temp_over_warning; // R12
            tsd_prev <= overtemp_shutdown_sense;
        end
    end

    // ----------------------------------------
    // power-up sequence timer
    // ----------------------------------------
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hw_prev <= 1'b0;
            seq_run <= 1'b0;
            slot_cnt <= 15'h0000;
            slot_num <= 5'h00;
            no_restart <= 1'b0;
        end else begin
            hw_prev <= hw_enable_pin;
            if (!hw_enable_pin) begin
                seq_run <= 1'b0;
                no_restart <= 1'b0;
            end else if (tsd_end && policy == `RESR_POLICY_NONE) begin
                // refused re-arm holds rails off until the pin drops
                no_restart <= 1'b1; // R4
                // policy 11 restarts nothing and resets nothing
            end else if ((!hw_prev && !no_restart) || (tsd_end && policy != `RESR_POLICY_NONE
                         && policy != 2'h3)) begin
                seq_run <= 1'b1; // R5 R6 R16
                slot_cnt <= 15'h0000;
                slot_num <= 5'h00;
            end else if (slot_tick) begin
                slot_cnt <= 15'h0000;
                if (slot_num == `RESR_SEQ_LAST_SLOT) begin
                    seq_run <= 1'b0; // R16
                end
                slot_num <= slot_num + 5'h01;
            end else if (seq_run) begin
                slot_cnt <= slot_cnt + 15'h0001;
            end
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rail_enable_ctrl <= `RESR_RST_RAIL_ENABLE;
            discharge_rearm_ctrl <= `RESR_RST_DISCHARGE;
        end else if (tsd_end && policy == `RESR_POLICY_RESET) begin
            // a shutdown end with policy 00 beats a host write
            rail_enable_ctrl <= `RESR_RST_RAIL_ENABLE; // R6
            discharge_rearm_ctrl <= `RESR_RST_DISCHARGE; // R6
        end else if (reg_wr) begin
            if (reg_addr == `RESR_ADDR_RAIL_ENABLE) begin
                rail_enable_ctrl <= reg_wdata & 8'hbf; // R18
            end
            if (reg_addr == `RESR_ADDR_DISCHARGE) begin
                discharge_rearm_ctrl <= reg_wdata;
            end
        end
    end

    // ----------------------------------------
    // event flags
    // ----------------------------------------
    resr_event_latch #(.DUAL_EDGE(1)) u_ev_uv (
        .sys_clk(sys_clk), .rst_n(rst_n), .sense(undervoltage_sense), // R13
        .clear(ev_read), .flag(undervoltage_event)
    );
    // sequence sense idles high, so no false edge after reset
    resr_event_latch #(.DUAL_EDGE(0), .SENSE_IDLE(1)) u_ev_seq (
        .sys_clk(sys_clk), .rst_n(rst_n), .sense(sequence_done_sense), // R14
        .clear(ev_read), .flag(sequence_done_event)
    );
    resr_event_latch #(.DUAL_EDGE(1)) u_ev_tsd (
        .sys_clk(sys_clk), .rst_n(rst_n), .sense(overtemp_shutdown_sense), // R15
        .clear(ev_read), .flag(overtemp_shutdown_event)
    );
    resr_event_latch #(.DUAL_EDGE(1)) u_ev_warn (
        .sys_clk(sys_clk), .rst_n(rst_n), .sense(overtemp_warning_sense), // R15
        .clear(ev_read), .flag(overtemp_warning_event)
    );

    assign sense_word = {4'h0, undervoltage_sense, sequence_done_sense,
                         overtemp_shutdown_sense, overtemp_warning_sense}; // R18
    assign event_word = {4'h0, undervoltage_event, sequence_done_event,
                         overtemp_shutdown_event, overtemp_warning_event}; // R17

    // ----------------------------------------
    // read port and outputs
    // ----------------------------------------
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            buck_level_select <= 1'b1;
            buck_on <= 1'b0;
            linear_reg_on <= 5'h00;
            buck_discharge_on <= 1'b1;
            linear_reg_discharge_on <= 5'h1f;
            sequencing <= 1'b0;
        end else begin
            if (reg_rd) begin
                case (reg_addr)
                    `RESR_ADDR_RAIL_ENABLE: reg_rdata <= rail_enable_ctrl;
                    `RESR_ADDR_DISCHARGE: reg_rdata <= discharge_rearm_ctrl;
                    `RESR_ADDR_SENSE: reg_rdata <= sense_word;
                    `RESR_ADDR_EVENT: reg_rdata <= event_word; // R17
                    default: reg_rdata <= 8'h00;
                endcase
            end
            buck_level_select <= rail_enable_ctrl[`RESR_BIT_LEVEL_SEL]; // R1
            // rails held off in shutdown and after a refused re-arm
            buck_on <= rail_enable_ctrl[`RESR_BIT_BUCK] & hw_enable_pin
                       & ~overtemp_shutdown_sense & ~no_restart; // R2
            linear_reg_on <= rail_enable_ctrl[4:0] & {5{hw_enable_pin & ~overtemp_shutdown_sense
                             & ~no_restart}}; // R3
            buck_discharge_on <= discharge_rearm_ctrl[`RESR_BIT_BUCK]; // R7
            linear_reg_discharge_on <= discharge_rearm_ctrl[4:0]; // R8
            sequencing <= seq_run;
        end
    end
endmodule
`default_nettype wire

/* resr_defs.vh */
// Purpose: constants of the regulator enable and status register group
// Assumes: 200 MHz sys_clk
// Notes: offsets are byte addresses on the register port
`ifndef RESR_DEFS_VH
`define RESR_DEFS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define RESR_ADDR_RAIL_ENABLE 8'h08
`define RESR_ADDR_DISCHARGE 8'h09
`define RESR_ADDR_SENSE 8'h0a
`define RESR_ADDR_EVENT 8'h0b
// ----------------------------------------
// reset values
// ----------------------------------------
`define RESR_RST_RAIL_ENABLE 8'h80
`define RESR_RST_DISCHARGE 8'h3f
`define RESR_RST_SENSE 8'h04
`define RESR_RST_EVENT 8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define RESR_BIT_LEVEL_SEL 7
`define RESR_BIT_BUCK 5
`define RESR_POLICY_HI 7
`define RESR_POLICY_LO 6
`define RESR_POLICY_RESET 2'h0
`define RESR_POLICY_KEEP 2'h1
`define RESR_POLICY_NONE 2'h2
// ----------------------------------------
// timing
// ----------------------------------------
`define RESR_CLK_MHZ 200
`define RESR_SEQ_SLOT_US 128
`define RESR_SEQ_SLOT_CYC (`RESR_SEQ_SLOT_US * `RESR_CLK_MHZ)
`define RESR_SEQ_SLOTS 16
`define RESR_SEQ_LAST_SLOT 5'h0f
`endif

/* resr_event_latch.v */
// Purpose: sticky event flag on an edge of a sense bit
// Assumes: sense is already synchronous
// Notes: a new edge wins over a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module resr_event_latch #(
    parameter DUAL_EDGE = 1,
    parameter SENSE_IDLE = 0
) (
    input wire sys_clk, // clock
    input wire rst_n, // async reset, low
    input wire sense, // live sense bit
    input wire clear, // clear by read
    output reg flag // latched event
);
    reg sense_prev;
    wire edge_seen;

    assign edge_seen = (DUAL_EDGE != 0) ? (sense ^ sense_prev) : (sense & ~sense_prev);

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sense_prev <= (SENSE_IDLE != 0);
            flag <= 1'b0;
        end else begin
            sense_prev <= sense;
            flag <= edge_seen | (flag & ~clear);
        end
    end
endmodule
`default_nettype wire

/* resr_regs_asserts.sv */
// Purpose: port checker of the regulator register group
// Assumes: SLOT_CYC of 4, so a power-up sequence lasts 64 cycles
// Notes: writes on the register port are spaced three cycles or more
`timescale 1ns/1ps
`default_nettype none
module resr_regs_asserts (
    input wire sys_clk, // clock
    input wire rst_n, // reset
    input wire [7:0] reg_addr, // offset
    input wire [7:0] reg_wdata, // write data
    input wire reg_wr, // write strobe
    input wire reg_rd, // read strobe
    input wire [7:0] reg_rdata, // read data
    input wire hw_enable_pin, // enable pin
    input wire uv_below, // below lockout
    input wire uv_above_hyst, // above release
    input wire temp_over_shutdown, // shutdown temp
    input wire temp_over_warning, // warning temp
    input wire buck_level_select, // level pick
    input wire buck_on, // buck enable
    input wire [4:0] linear_reg_on, // linear enables
    input wire buck_discharge_on, // buck discharge
    input wire [4:0] linear_reg_discharge_on, // linear discharge
    input wire sequencing // sequence running
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_running;
        sequencing ##63 sequencing;
    endsequence
    sequence s_sense_read;
        reg_rd && reg_addr == 8'h0a;
    endsequence
    a_level_follow: assert property (reg_wr && reg_addr == 8'h08 |-> ##2
        buck_level_select == $past(reg_wdata[7], 2)) else $error("level select lost");
    a_discharge_follow: assert property (reg_wr && reg_addr == 8'h09 |-> ##2
        {buck_discharge_on, linear_reg_discharge_on} == $past(reg_wdata[5:0], 2)) else $error("discharge lost");
    a_shutdown_off: assert property (temp_over_shutdown [*2] |=> !buck_on && linear_reg_on == 5'h00)
        else $error("rail on in shutdown");
    a_pin_off: assert property (!hw_enable_pin [*2] |=> !buck_on && linear_reg_on == 5'h00)
        else $error("rail on with pin low");
    a_seq_length: assert property ($rose(hw_enable_pin) |-> ##2 s_running ##[1:2] !sequencing)
        else $error("sequence length wrong");
    a_uv_sense: assert property (uv_below [*3] ##0 s_sense_read |=> reg_rdata[3] == 1'b1)
        else $error("undervoltage not seen");
    a_warn_sense: assert property (temp_over_warning [*3] ##0 s_sense_read |=> reg_rdata[0] == 1'b1)
        else $error("warning not seen");
    a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h08 || reg_addr > 8'h0b) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_spare_zero: assert property (reg_rd && reg_addr[7:1] == 7'h05 |=> reg_rdata[7:4] == 4'h0)
        else $error("spare bits set");
endmodule
`default_nettype wire

/* resr_host.sv */
// Purpose: register-port host in place of the serial controller
// Assumes: one transfer at a time
// Notes: released address and data show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module resr_host (
    input wire sys_clk, // clock
    input wire [7:0] reg_rdata, // read data
    output logic [7:0] reg_addr = 8'h00, // offset
    output logic [7:0] reg_wdata = 8'h00, // write data
    output logic reg_wr = 1'b0, // write strobe
    output logic reg_rd = 1'b0 // read strobe
);
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge sys_clk);
        reg_addr <= ~a;
        reg_wdata <= ~d;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        #1 q = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* testbench.sv */
// Purpose: self-checking bench of the regulator register group
// Assumes: SLOT_CYC of 4, so a power-up sequence lasts 64 cycles
// Notes: rows hold {write, offset, data, expected readback}
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; $display("unexpected %0t got %h", $time, g); end end
module testbench;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hw_enable_pin = 1'b0, uv_below = 1'b0, uv_above_hyst = 1'b1;
    logic temp_over_shutdown = 1'b0, temp_over_warning = 1'b0;
    wire [7:0] reg_addr, reg_wdata, reg_rdata;
    wire reg_wr, reg_rd, buck_level_select, buck_on, buck_discharge_on, sequencing;
    wire [4:0] linear_reg_on, linear_reg_discharge_on;
    int bad_count = 0, checked = 0, cycles = 0;
    logic [7:0] q;
    logic [31:0] rows [11] = '{32'h00_08_00_80, 32'h00_09_00_3f, 32'h00_0a_00_04, 32'h00_0b_00_00,
        32'h01_08_ff_bf, 32'h01_08_40_00, 32'h01_09_ff_ff, 32'h01_09_40_40, 32'h01_0a_ff_04,
        32'h01_0b_ff_00, 32'h01_3c_ff_00};
    always #2.5 sys_clk = ~sys_clk;
    resr_host i_resr_host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
    resr_regs #(.SLOT_CYC(4)) i_resr_regs (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .hw_enable_pin(hw_enable_pin), .uv_below(uv_below), .uv_above_hyst(uv_above_hyst),
        .temp_over_shutdown(temp_over_shutdown), .temp_over_warning(temp_over_warning),
        .buck_level_select(buck_level_select), .buck_on(buck_on), .linear_reg_on(linear_reg_on),
        .buck_discharge_on(buck_discharge_on), .linear_reg_discharge_on(linear_reg_discharge_on),
        .sequencing(sequencing));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_resr_host.access(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_resr_host.access(1'b0, a, 8'h00, q);
        `CHK(q, e)
    endtask
    task automatic tsd_pulse;
        @(posedge sys_clk) temp_over_shutdown <= 1'b1;
        rd(8'h0a, 8'h06);
        `CHK(buck_on, 1'b0)
        @(posedge sys_clk) temp_over_shutdown <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic end_sim;
        if (bad_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            end_sim;
        end
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i][24]) begin
                wr(rows[i][23:16], rows[i][15:8]);
            end
            rd(rows[i][23:16], rows[i][7:0]);
        end
        wr(8'h08, 8'hbf);
        @(posedge sys_clk) hw_enable_pin <= 1'b1;
        rd(8'h0a, 8'h00);
        rd(8'h0b, 8'h00);
        repeat (70) @(posedge sys_clk);
        rd(8'h0a, 8'h04);
        rd(8'h0b, 8'h04);
        rd(8'h0b, 8'h00);
        `CHK({buck_on, linear_reg_on}, 6'h3f)
        @(posedge sys_clk) {uv_below, uv_above_hyst, temp_over_warning} <= 3'b101;
        repeat (3) @(posedge sys_clk);
        rd(8'h0a, 8'h0d);
        rd(8'h0b, 8'h09);
        @(posedge sys_clk) uv_below <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rd(8'h0a, 8'h0d);
        @(posedge sys_clk) {uv_above_hyst, temp_over_warning} <= 2'b10;
        repeat (3) @(posedge sys_clk);
        rd(8'h0a, 8'h04);
        rd(8'h0b, 8'h09);
        wr(8'h09, 8'h7f);
        tsd_pulse;
        rd(8'h08, 8'hbf);
        `CHK(sequencing, 1'b1)
        rd(8'h0b, 8'h02);
        repeat (70) @(posedge sys_clk);
        wr(8'h09, 8'h00);
        tsd_pulse;
        rd(8'h08, 8'h80);
        rd(8'h09, 8'h3f);
        `CHK(sequencing, 1'b1)
        repeat (70) @(posedge sys_clk);
        wr(8'h08, 8'hbf);
        wr(8'h09, 8'hbf);
        tsd_pulse;
        #1 `CHK(sequencing, 1'b0)
        repeat (70) @(posedge sys_clk);
        `CHK({buck_on, sequencing}, 2'b00)
        wr(8'h09, 8'h80);
        wr(8'h08, 8'h20);
        `CHK({buck_level_select, buck_on, buck_discharge_on, linear_reg_discharge_on}, 8'h00)
        @(posedge sys_clk) rst_n <= 1'b0;
        #1 `CHK({buck_level_select, buck_on, linear_reg_on, sequencing}, 8'h80)
        `CHK({buck_discharge_on, linear_reg_discharge_on}, 6'h3f)
        @(posedge sys_clk) rst_n <= 1'b1;
        rd(8'h0b, 8'h00);
        rd(8'h0a, 8'h00);
        rd(8'h08, 8'h80);
        end_sim;
    end
endmodule
bind resr_regs resr_regs_asserts i_resr_regs_asserts (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hw_enable_pin(hw_enable_pin), .uv_below(uv_below), .uv_above_hyst(uv_above_hyst),
    .temp_over_shutdown(temp_over_shutdown), .temp_over_warning(temp_over_warning),
    .buck_level_select(buck_level_select), .buck_on(buck_on), .linear_reg_on(linear_reg_on),
    .buck_discharge_on(buck_discharge_on), .linear_reg_discharge_on(linear_reg_discharge_on),
    .sequencing(sequencing));
`default_nettype wire
